/* design/amoc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module amoc_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_extended_ctrl_enable_pin,
    input wire logic i_interleave_pin,
    input wire logic i_bus_split_select,
    input wire logic i_output_phase_select,
    input wire logic i_power_down_i,
    input wire logic i_power_down_q,
    input wire logic i_pattern_output_select,
    input wire logic i_cal_pin,
    input wire logic i_link_clk,
    input wire logic [9:0] i_sample_i,
    input wire logic [9:0] i_sample_q,
    input wire logic i_under_i,
    input wire logic i_over_i,
    input wire logic i_under_q,
    input wire logic i_over_q,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic [9:0] o_bus_i,
    output logic [9:0] o_bus_id,
    output logic [9:0] o_bus_q,
    output logic [9:0] o_bus_qd,
    output logic o_oe_i,
    output logic o_oe_id,
    output logic o_oe_q,
    output logic o_oe_qd,
    output logic o_over_range_i,
    output logic o_over_range_q,
    output logic o_data_clk,
    output logic o_cal_request,
    output logic o_serial_active,
    output logic o_irq
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [1:0] ece_s;
        logic [1:0] il_s;
        logic [1:0] split_s;
        logic [1:0] phase_s;
        logic [1:0] pdi_s;
        logic [1:0] pdq_s;
        logic [1:0] pat_s;
        logic [1:0] cal_s;
        logic [1:0] lclk_s;
        logic lclk_d;
        logic [15:0] cfg;
        logic [3:0] status;
        logic [3:0] irq_en;
        logic [3:0] mode_d;
        logic half;
        logic [9:0] hold_i;
        logic [9:0] hold_q;
        logic [9:0] pat;
        logic [15:0] rdata;
        logic [9:0] bus_i;
        logic [9:0] bus_id;
        logic [9:0] bus_q;
        logic [9:0] bus_qd;
        logic oe_i;
        logic oe_id;
        logic oe_q;
        logic oe_qd;
        logic ovr_i;
        logic ovr_q;
        logic dclk;
        logic cal_req;
        logic ser_act;
        logic irq;
    } amoc_state_s;

    amoc_state_s st_reg;
    amoc_state_s st_next;

    logic [15:0] scratch_reg [1:11];

    // ==========================================================
    // Combinational next state
    // ==========================================================
    always_comb begin
        logic extended_control_mode;
        logic il_on;
        logic use_q_in;
        logic demux;
        logic pd_i;
        logic pd_q;
        logic cal_now;
        logic lclk_rise;
        logic lclk_fall;
        logic [9:0] smp_i;
        logic [9:0] smp_q;
        logic [9:0] il_src_a;
        logic [9:0] il_src_b;
        logic ovr_i_now;
        logic ovr_q_now;
        logic [3:0] mode_now;
        logic [3:0] ev;
        extended_control_mode = 1'b0;
        il_on = 1'b0;
        use_q_in = 1'b0;
        demux = 1'b0;
        pd_i = 1'b0;
        pd_q = 1'b0;
        cal_now = 1'b0;
        lclk_rise = 1'b0;
        lclk_fall = 1'b0;
        smp_i = 10'h000;
        smp_q = 10'h000;
        il_src_a = 10'h000;
        il_src_b = 10'h000;
        ovr_i_now = 1'b0;
        ovr_q_now = 1'b0;
        mode_now = 4'h0;
        ev = 4'h0;
        st_next = st_reg;
        st_next.ece_s = {st_reg.ece_s[0], i_extended_ctrl_enable_pin};
        st_next.il_s = {st_reg.il_s[0], i_interleave_pin};
        st_next.split_s = {st_reg.split_s[0], i_bus_split_select};
        st_next.phase_s = {st_reg.phase_s[0], i_output_phase_select};
        st_next.pdi_s = {st_reg.pdi_s[0], i_power_down_i};
        st_next.pdq_s = {st_reg.pdq_s[0], i_power_down_q};
        st_next.pat_s = {st_reg.pat_s[0], i_pattern_output_select};
        st_next.cal_s = {st_reg.cal_s[0], i_cal_pin};
        st_next.lclk_s = {st_reg.lclk_s[0], i_link_clk};
        st_next.lclk_d = st_reg.lclk_s[1];
        lclk_rise = st_reg.lclk_s[1] & ~st_reg.lclk_d;
        lclk_fall = ~st_reg.lclk_s[1] & st_reg.lclk_d;

        // ==========================================================
        // Mode decode
        // ==========================================================
        extended_control_mode = ~st_reg.ece_s[1];
        // a floating pin reaches here as high and powers down
        pd_i = st_reg.pdi_s[1] | (extended_control_mode & st_reg.cfg[amoc_pkg::CFG_PD_I_BIT]);
        pd_q = st_reg.pdq_s[1] | (extended_control_mode & st_reg.cfg[amoc_pkg::CFG_PD_Q_BIT]);
        il_on = extended_control_mode ? st_reg.cfg[amoc_pkg::CFG_IL_EN_BIT] : st_reg.il_s[1];
        use_q_in = extended_control_mode & st_reg.cfg[amoc_pkg::CFG_IL_QSEL_BIT];
        demux = ~st_reg.split_s[1];
        cal_now = st_reg.cal_s[1] | (extended_control_mode & st_reg.cfg[amoc_pkg::CFG_CAL_BIT]);

        // ==========================================================
        // Sample clamp
        // ==========================================================
        // clamp out-of-range words and flag them
        ovr_i_now = i_under_i | i_over_i;
        ovr_q_now = i_under_q | i_over_q;
        smp_i = i_under_i ? 10'h000 : (i_over_i ? 10'h3FF : i_sample_i);
        smp_q = i_under_q ? 10'h000 : (i_over_q ? 10'h3FF : i_sample_q);
        // both converters take the selected input, other deactivated
        il_src_a = use_q_in ? smp_q : smp_i;
        il_src_b = use_q_in ? smp_q : smp_i;

        st_next.ser_act = extended_control_mode;
        st_next.cal_req = cal_now;
        ev = '0;

        // ==========================================================
        // Output buses
        // ==========================================================
        if (lclk_rise) begin
            st_next.half = ~st_reg.half;
            st_next.pat = st_reg.pat + amoc_pkg::PAT_STEP;
            // edge phase toggles the data clock with the word
            if (!st_reg.phase_s[1]) begin
                st_next.dclk = ~st_reg.dclk;
            end
            if (st_reg.pat_s[1]) begin
                st_next.bus_i = st_reg.pat;
                st_next.bus_id = ~st_reg.pat;
                st_next.bus_q = st_reg.pat;
                st_next.bus_qd = ~st_reg.pat;
                st_next.ovr_i = st_reg.pat[0];
                st_next.ovr_q = ~st_reg.pat[0];
            end else if (il_on) begin
                // interleave goes out on the Q side buses, and on the I side buses too when demuxed
                st_next.ovr_i = 1'b0;
                st_next.ovr_q = use_q_in ? ovr_q_now : ovr_i_now;
                if (demux) begin
                    if (st_reg.half) begin
                        st_next.bus_q = st_reg.hold_q;
                        st_next.bus_qd = il_src_b;
                        st_next.bus_i = st_reg.hold_i;
                        st_next.bus_id = il_src_a;
                    end else begin
                        st_next.hold_i = il_src_a;
                        st_next.hold_q = il_src_b;
                    end
                end else begin
                    st_next.bus_q = il_src_a;
                    st_next.bus_qd = il_src_b;
                end
            end else begin
                st_next.ovr_i = ovr_i_now;
                st_next.ovr_q = ovr_q_now;
                if (demux) begin
                    // pair two samples onto two buses at half rate
                    if (st_reg.half) begin
                        st_next.bus_i = st_reg.hold_i;
                        st_next.bus_id = smp_i;
                        st_next.bus_q = st_reg.hold_q;
                        st_next.bus_qd = smp_q;
                    end else begin
                        st_next.hold_i = smp_i;
                        st_next.hold_q = smp_q;
                    end
                end else begin
                    st_next.bus_i = smp_i;
                    st_next.bus_q = smp_q;
                end
            end
        end

        // midway phase toggles the data clock between words
        if (lclk_fall && st_reg.phase_s[1]) begin
            st_next.dclk = ~st_reg.dclk;
        end

        // bus enables per mode and power state
        if (st_reg.pat_s[1]) begin
            st_next.oe_i = 1'b1;
            st_next.oe_id = 1'b1;
            st_next.oe_q = 1'b1;
            st_next.oe_qd = 1'b1;
        end else if (il_on) begin
            st_next.oe_q = ~pd_q;
            st_next.oe_qd = ~pd_q;
            st_next.oe_i = demux & ~pd_i;
            st_next.oe_id = demux & ~pd_i;
        end else begin
            st_next.oe_i = ~pd_i;
            st_next.oe_id = demux & ~pd_i;
            st_next.oe_q = ~pd_q;
            st_next.oe_qd = demux & ~pd_q;
        end

        // ==========================================================
        // Register bank: only reachable in extended mode
        // ==========================================================
        st_next.rdata = '0;
        if (i_rd && extended_control_mode) begin
            case (i_addr)
                amoc_pkg::CFG_ADDR: st_next.rdata = st_reg.cfg;
                amoc_pkg::STAT_ADDR: st_next.rdata = {12'h000, st_reg.status};
                amoc_pkg::IRQ_EN_ADDR: st_next.rdata = {12'h000, st_reg.irq_en};
                amoc_pkg::IRQ_CLR_ADDR: st_next.rdata = 16'h0000;
                amoc_pkg::MODE_ADDR: st_next.rdata = {12'h000, st_reg.mode_d};
                default: st_next.rdata = scratch_reg[i_addr];
            endcase
        end
        if (!extended_control_mode) begin
            st_next.cfg = amoc_pkg::CFG_RESET;
        end else if (i_wr && i_addr == amoc_pkg::CFG_ADDR) begin
            st_next.cfg = i_wdata;
        end
        if (i_wr && extended_control_mode && i_addr == amoc_pkg::IRQ_EN_ADDR) begin
            st_next.irq_en = i_wdata[3:0];
        end

        // ==========================================================
        // Interrupts
        // ==========================================================
        mode_now = {st_reg.pat_s[1], demux, il_on, extended_control_mode};
        st_next.mode_d = mode_now;
        ev[amoc_pkg::IRQ_OVR_I] = lclk_rise & ovr_i_now;
        ev[amoc_pkg::IRQ_OVR_Q] = lclk_rise & ovr_q_now;
        ev[amoc_pkg::IRQ_MODE_CHG] = (mode_now != st_reg.mode_d);
        ev[amoc_pkg::IRQ_PAT] = st_reg.pat_s[1];
        if (i_wr && extended_control_mode && i_addr == amoc_pkg::IRQ_CLR_ADDR) begin
            st_next.status = st_reg.status & ~i_wdata[3:0];
        end
        st_next.status = st_next.status | ev;
        st_next.irq = |(st_next.status & st_reg.irq_en);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Start in pin control so no extended-mode pulse follows reset
            st_reg <= '{ece_s: 2'b11, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Spare registers of the bank, cleared when pin control is chosen
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 1; k < 12; k++) begin
                scratch_reg[k] <= 16'h0000;
            end
        end else if (st_reg.ece_s[1]) begin
            for (int k = 1; k < 12; k++) begin
                scratch_reg[k] <= 16'h0000;
            end
        end else if (i_wr && i_addr >= 4'h1 && i_addr <= 4'hB) begin
            scratch_reg[i_addr] <= i_wdata;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_bus_i = st_reg.bus_i;
    assign o_bus_id = st_reg.bus_id;
    assign o_bus_q = st_reg.bus_q;
    assign o_bus_qd = st_reg.bus_qd;
    assign o_oe_i = st_reg.oe_i;
    assign o_oe_id = st_reg.oe_id;
    assign o_oe_q = st_reg.oe_q;
    assign o_oe_qd = st_reg.oe_qd;
    assign o_over_range_i = st_reg.ovr_i;
    assign o_over_range_q = st_reg.ovr_q;
    assign o_data_clk = st_reg.dclk;
    assign o_cal_request = st_reg.cal_req;
    assign o_serial_active = st_reg.ser_act;
    assign o_irq = st_reg.irq;
endmodule
`default_nettype wire

/* design/amoc_pkg.sv */
package amoc_pkg;
    // Sample and bus widths
    localparam int SAMPLE_W = 10;
    localparam int REG_COUNT = 16;
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 16;
    // Configuration register (index 0) fields
    localparam logic [3:0] CFG_ADDR = 4'h0;
    localparam int CFG_CAL_BIT = 15;
    localparam int CFG_PHASE_BIT = 14;
    localparam int CFG_PD_I_BIT = 11;
    localparam int CFG_PD_Q_BIT = 10;
    localparam int CFG_IL_EN_BIT = 7;
    localparam int CFG_IL_QSEL_BIT = 6;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // Status, interrupt enable, clear and mode registers
    localparam logic [3:0] STAT_ADDR = 4'hC;
    localparam logic [3:0] IRQ_EN_ADDR = 4'hD;
    localparam logic [3:0] IRQ_CLR_ADDR = 4'hE;
    localparam logic [3:0] MODE_ADDR = 4'hF;
    localparam int IRQ_W = 4;
    localparam int IRQ_OVR_I = 0;
    localparam int IRQ_OVR_Q = 1;
    localparam int IRQ_MODE_CHG = 2;
    localparam int IRQ_PAT = 3;
    // Test pattern seed
    localparam logic [9:0] PAT_SEED = 10'h155;
    localparam logic [9:0] PAT_STEP = 10'h001;
endpackage

/* test/amoc_props.sv */
`timescale 1ns/100ps
`default_nettype none
module amoc_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_extended_ctrl_enable_pin,
    input wire logic i_interleave_pin,
    input wire logic i_bus_split_select,
    input wire logic i_power_down_i,
    input wire logic i_power_down_q,
    input wire logic i_pattern_output_select,
    input wire logic i_cal_pin,
    input wire logic i_link_clk,
    input wire logic i_under_i,
    input wire logic i_over_i,
    input wire logic i_over_q,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [9:0] o_bus_i,
    input wire logic [9:0] o_bus_q,
    input wire logic o_oe_i,
    input wire logic o_oe_id,
    input wire logic o_oe_qd,
    input wire logic o_over_range_i,
    input wire logic o_over_range_q,
    input wire logic o_cal_request,
    input wire logic o_serial_active
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic plain;
    // Pin mode, independent sampling, one bus per channel, no pattern, I channel not powered down
    assign plain = !o_serial_active && i_bus_split_select && !i_interleave_pin
        && !i_pattern_output_select && !i_power_down_i;
    serial_off_a: assert property (i_extended_ctrl_enable_pin [*5] |-> !o_serial_active)
        else $error("serial port active in pin mode");
    serial_on_a: assert property (!i_extended_ctrl_enable_pin [*5] |-> o_serial_active)
        else $error("serial port idle in extended mode");
    pin_read_zero_a:
        assert property (i_extended_ctrl_enable_pin [*5] ##0 i_rd |=> o_rdata == 16'h0000)
        else $error("register read answered in pin mode");
    cal_or_a: assert property (i_cal_pin [*5] |-> o_cal_request)
        else $error("calibrate pin not passed on");
    under_clamp_a:
        assert property ($rose(i_link_clk) && plain && i_under_i && !i_over_i
            |-> ##[3:8] (o_bus_i == 10'h000 && o_over_range_i))
        else $error("below range word not zero with flag");
    over_clamp_a:
        assert property ($rose(i_link_clk) && plain && !i_power_down_q && i_over_q
            |-> ##[3:8] (o_bus_q == 10'h3FF && o_over_range_q))
        else $error("above range word not all ones with flag");
    pd_hiz_a:
        assert property ($rose(i_link_clk) && i_power_down_i && !i_pattern_output_select
            |-> ##[3:8] (!o_oe_i && !o_oe_id))
        else $error("powered down channel still drives");
    nondemux_oe_a:
        assert property ($rose(i_link_clk) && plain |-> ##[3:8] (!o_oe_id && !o_oe_qd))
        else $error("second bus active without demux");
    demux_oe_a:
        assert property ($rose(i_link_clk) && !o_serial_active && !i_bus_split_select
            && !i_power_down_i && !i_pattern_output_select |-> ##[3:8] (o_oe_i && o_oe_id))
        else $error("demux buses not both active");
endmodule
bind amoc_top amoc_props u_props (.i_clk, .i_sys_rst, .i_extended_ctrl_enable_pin,
    .i_interleave_pin, .i_bus_split_select, .i_power_down_i, .i_power_down_q,
    .i_pattern_output_select, .i_cal_pin, .i_link_clk, .i_under_i, .i_over_i, .i_over_q,
    .i_rd, .o_rdata, .o_bus_i, .o_bus_q, .o_oe_i, .o_oe_id, .o_oe_qd, .o_over_range_i,
    .o_over_range_q, .o_cal_request, .o_serial_active);
`default_nettype wire

/* test/amoc_capture.sv */
`timescale 1ns/100ps
`default_nettype none
// Capture logic: takes a word on every data clock transition
module amoc_capture (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_data_clk,
    input wire logic [9:0] i_bus,
    output logic [9:0] o_word,
    output logic [15:0] o_edges
);
    logic dclk_reg;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dclk_reg <= 1'b0;
            o_word <= 10'h000;
            o_edges <= 16'h0000;
        end else begin
            dclk_reg <= i_data_clk;
            if (dclk_reg != i_data_clk) begin
                o_word <= i_bus;
                o_edges <= o_edges + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, ece = 1'b1, ilv = 1'b0, split = 1'b1, phase = 1'b0;
    logic power_down_i = 1'b0, power_down_q = 1'b0, pat = 1'b0, cal = 1'b0, lclk = 1'b0, wr = 1'b0, rd = 1'b0;
    logic ui = 1'b0, oi = 1'b0, uq = 1'b0, oq = 1'b0;
    logic [9:0] si = 10'h000, sq = 10'h000;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, dat, edges, rv;
    logic [9:0] bi, bid, bq, bqd, cw;
    logic oei, oeid, oeq, oeqd, over_range_i, over_range_q, dclk, calr, ser, irq;
    logic [3:0] fls [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
    int err_total = 0, cmp_count = 0, n;
    int qi[$], qq[$];
    always #4 clk = ~clk;
    always #62.5 lclk = ~lclk;
    amoc_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_extended_ctrl_enable_pin(ece),
        .i_interleave_pin(ilv), .i_bus_split_select(split), .i_output_phase_select(phase),
        .i_power_down_i(power_down_i), .i_power_down_q(power_down_q), .i_pattern_output_select(pat),
        .i_cal_pin(cal), .i_link_clk(lclk), .i_sample_i(si), .i_sample_q(sq),
        .i_under_i(ui), .i_over_i(oi), .i_under_q(uq), .i_over_q(oq), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_bus_i(bi),
        .o_bus_id(bid), .o_bus_q(bq), .o_bus_qd(bqd), .o_oe_i(oei), .o_oe_id(oeid),
        .o_oe_q(oeq), .o_oe_qd(oeqd), .o_over_range_i(over_range_i), .o_over_range_q(over_range_q),
        .o_data_clk(dclk), .o_cal_request(calr), .o_serial_active(ser), .o_irq(irq));
    amoc_capture i_cap (.i_clk(clk), .i_sys_rst(rst), .i_data_clk(dclk), .i_bus(bq),
        .o_word(cw), .o_edges(edges));
    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 dat = rdata;
    endtask
    // One converter word per link period, held across its detection
    task automatic step(input logic [3:0] fl);
        logic [9:0] a, b;
        a = 10'($urandom);
        b = 10'($urandom);
        @(negedge lclk);
        @(posedge clk);
        si <= a;
        sq <= b;
        {ui, oi, uq, oq} <= fl;
        qi.push_front(fl[3] ? 0 : fl[2] ? 1023 : int'(a));
        qq.push_front(fl[1] ? 0 : fl[0] ? 1023 : int'(b));
        @(posedge lclk);
        repeat (7) @(posedge clk);
        #1;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        void'($urandom(13498));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            step(fls[k]);
            chk(16'(bi), 16'(qi[0]));
            chk(16'(bq), 16'(qq[0]));
            chk(16'({over_range_i, over_range_q}), {14'h0000, fls[k][3] | fls[k][2], fls[k][1] | fls[k][0]});
            chk(16'({oeid, oeqd, ser}), 16'h0000);
        end
        $display("test 1 done");
        @(posedge clk);
        split <= 1'b0;
        step(4'h0);
        n = 0;
        for (int k = 0; k < 4; k++) begin
            step(4'h0);
            if (bi === 10'(qi[1]) && bid === 10'(qi[0]) &&
                bq === 10'(qq[1]) && bqd === 10'(qq[0])) begin
                n++;
            end
        end
        chk(16'(n), 16'h0002);
        chk(16'({oei, oeid}), 16'h0003);
        chk(16'(edges !== 16'h0000), 16'h0001);
        $display("test 2 done");
        @(posedge clk);
        split <= 1'b1;
        ilv <= 1'b1;
        step(4'h0);
        step(4'h9);
        chk(16'(bq), 16'(qi[0]));
        chk(16'({over_range_i, oeq, oeqd}), 16'h0003);
        $display("test 3 done");
        @(posedge clk);
        ilv <= 1'b0;
        power_down_i <= 1'b1;
        step(4'h0);
        chk(16'({oei, oeid, oeq}), 16'h0001);
        @(posedge clk);
        phase <= 1'b1;
        step(4'h0);
        n = int'(edges);
        @(negedge lclk);
        repeat (6) @(posedge clk);
        #1 chk(edges - 16'(n), 16'h0001);
        chk(16'(cw), 16'(bq));
        $display("test 4 done");
        @(posedge clk);
        power_down_i <= 1'b0;
        ece <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(16'(ser), 16'h0001);
        wreg(4'h0, 16'h00C0);
        rreg(4'h0);
        chk(dat, 16'h00C0);
        rv = 16'($urandom);
        wreg(4'h5, rv);
        rreg(4'h5);
        chk(dat, rv);
        step(4'h0);
        step(4'h0);
        chk(16'(bq), 16'(qq[0]));
        wreg(4'h0, 16'h0000);
        wreg(4'hE, 16'h000F);
        wreg(4'hD, 16'h0000);
        step(4'h8);
        chk(16'(irq), 16'h0000);
        wreg(4'hD, 16'h0001);
        rreg(4'hC);
        chk(dat & 16'h0001, 16'h0001);
        chk(16'(irq), 16'h0001);
        step(4'h0);
        wreg(4'hE, 16'h0001);
        rreg(4'hC);
        chk(16'(irq), 16'h0000);
        $display("test 5 done");
        @(posedge clk);
        ece <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(4'h5);
        chk(dat, 16'h0000);
        @(posedge clk);
        cal <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(16'(calr), 16'h0001);
        $display("test 6 done");
        @(posedge clk);
        cal <= 1'b0;
        pat <= 1'b1;
        step(4'h0);
        chk(16'({oei, oeid, oeq, oeqd}), 16'h000F);
        $display("test 7 done");
        conclude;
    end
    initial begin
        #100000;
        err_total++;
        conclude;
    end
endmodule
`default_nettype wire
